// ==== src/ibs_sequencer.sv ====
// ibs_sequencer.sv: four-state external bus cycle sequencer with separate or
// multiplexed address/data; per chip select configuration arrives as ports
// assumes requests are held stable while req_valid waits for req_ready
`timescale 1ns/1ps
`include "ibs_map.svh"

// Behaviour
// - every cycle walks T1, T2, T3, T4
// - state length programmable 2 to 15 clocks
// - latch strobe high at T1 start, low midway
// - separate write: address, select, data in T1
// - separate write: write strobe low in T2
// - memory or io request low from T2
// - T3 leaves all bus outputs unchanged
// - wait low before T3 inserts wait states
// - read data captured at T4 start, strobe off
// - write strobe off at T4, buses held
// - cycle completes at T4 end only
// - muxed read: address on data bus, select
// - muxed read: T2 releases data, read strobe
// - muxed write: address on data, latch pulse
// - muxed write: T2 swaps in write data
// - muxed write: write strobe off at T4
// - separate read: address, select T1; read T2
// - muxed: low byte on data, full address too
// - mode and muxing per select; native default
module ibs_sequencer #(
  parameter int unsigned CS_N = `IBS_CS_N
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire ibs_pkg::ibs_req_t      req,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic [`IBS_DATA_W-1:0]      rsp_rdata,
  input  wire logic [CS_N-1:0]        cfg_we,
  input  wire ibs_pkg::ibs_cs_cfg_t   cfg_wdata,
  output ibs_pkg::ibs_cs_cfg_t        cfg_rdata [CS_N],
  output logic                        busy,
  output logic [`IBS_ADDR_W-1:0]      bus_addr,
  input  wire logic [`IBS_DATA_W-1:0] bus_data_in,
  output logic [`IBS_DATA_W-1:0]      bus_data_out,
  output logic                        bus_data_oe_n,
  output logic [CS_N-1:0]             chip_sel_n,
  output logic                        addr_latch,
  output logic                        read_n,
  output logic                        write_n,
  output logic                        memory_request_n,
  output logic                        io_request_n,
  input  wire logic                   wait_n
);
  import ibs_pkg::*;

  // the select field of a request is two bits, so four selects at most
  if (CS_N < 1 || CS_N > 4) begin : g_bad_cs_n
    $error("ibs_sequencer: CS_N must be 1 to 4");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_WAIT, ST_T4} ibs_state_t;

  ibs_state_t             state_q, state_d;
  ibs_cs_cfg_t            cfg_q [CS_N];
  ibs_req_t               req_q;
  logic                   muxed_q;
  logic [3:0]             len_q;
  logic [3:0]             cnt_q;
  logic                   wait_s1_q, wait_s2_q;
  logic                   wait_hit_q;
  logic [`IBS_DATA_W-1:0] rdata_q;
  logic                   rsp_q;

  function automatic logic [3:0] clamp_len(input logic [3:0] l);
    if (l < `IBS_STATE_LEN_MIN) return `IBS_STATE_LEN_MIN;
    return l;
  endfunction

  // per-select configuration, native after reset
  for (genvar g = 0; g < CS_N; g++) begin : g_cfg
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        cfg_q[g] <= '{mode: IBS_MODE_NATIVE, muxed: 1'b0, state_len: `IBS_STATE_LEN_RST};
      end else if (cfg_we[g]) begin
        cfg_q[g] <= cfg_wdata;
      end
    end
    assign cfg_rdata[g] = cfg_q[g];
  end

  wire          sel_ok    = 32'(req.cs) < CS_N;
  wire          sel_four  = sel_ok && cfg_q[req.cs].mode == IBS_MODE_FOUR;
  wire          start     = state_q == ST_IDLE && req_valid && sel_four;
  wire          last_clk  = cnt_q == len_q - 4'h1;
  wire          half_clk  = cnt_q >= (len_q >> 1);
  wire          is_wait   = ~wait_s2_q;

  // only the four-state mode is sequenced here; other modes are refused
  assign req_ready = state_q == ST_IDLE && sel_four;
  assign busy      = state_q != ST_IDLE;

  // two-flop sync; a late wait is simply seen one clock later
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_s1_q <= 1'b1;
      wait_s2_q <= 1'b1;
    end else begin
      wait_s1_q <= wait_n;
      wait_s2_q <= wait_s1_q;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = ST_T1;
      ST_T1:   if (last_clk) state_d = ST_T2;
      ST_T2:   if (last_clk) state_d = ST_T3;
      ST_T3:   if (last_clk) state_d = wait_hit_q ? ST_WAIT : ST_T4;
      ST_WAIT: if (last_clk && !is_wait) state_d = ST_T4;
      ST_T4:   if (last_clk) state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      len_q      <= `IBS_STATE_LEN_RST;
      muxed_q    <= 1'b0;
      req_q      <= '0;
      wait_hit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q || last_clk) ? 4'h0 : cnt_q + 4'h1;
      if (start) begin
        req_q   <= req;
        muxed_q <= cfg_q[req.cs].muxed;
        len_q   <= clamp_len(cfg_q[req.cs].state_len);
      end
      // wait sampled throughout T2, the last sample taken on the edge that opens T3
      if (state_q == ST_T2) wait_hit_q <= is_wait;
      else if (state_q == ST_IDLE) wait_hit_q <= 1'b0;
    end
  end

  // bus outputs, registered
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_addr         <= '0;
      bus_data_out     <= '0;
      bus_data_oe_n    <= 1'b1;
      chip_sel_n       <= '1;
      addr_latch       <= 1'b0;
      read_n           <= 1'b1;
      write_n          <= 1'b1;
      memory_request_n <= 1'b1;
      io_request_n     <= 1'b1;
    end else begin
      unique case (state_d)
        ST_IDLE: begin
          chip_sel_n    <= '1;
          bus_data_oe_n <= 1'b1;
          addr_latch    <= 1'b0;
        end
        ST_T1: begin
          if (start) begin
            bus_addr   <= req.addr;
            chip_sel_n <= ~(CS_N'(1) << req.cs);
            if (cfg_q[req.cs].muxed) begin
              bus_data_out  <= req.addr[`IBS_DATA_W-1:0];
              bus_data_oe_n <= 1'b0;
            end else begin
              bus_data_out  <= req.wdata;
              bus_data_oe_n <= ~req.write;
            end
          end
          addr_latch <= start || !(cnt_q + 4'h1 >= (len_q >> 1));
        end
        ST_T2: begin
          addr_latch <= 1'b0;
          if (state_q == ST_T1) begin
            read_n           <= req_q.write;
            write_n          <= ~req_q.write;
            memory_request_n <= req_q.io;
            io_request_n     <= ~req_q.io;
            bus_data_out     <= req_q.wdata;
            bus_data_oe_n    <= ~req_q.write;
          end
        end
        ST_T3, ST_WAIT: begin
          // nothing changes here; T2 values hold
        end
        ST_T4: begin
          read_n  <= 1'b1;
          write_n <= 1'b1;
        end
        default: ;
      endcase
      if (state_d == ST_IDLE && state_q == ST_T4) begin
        memory_request_n <= 1'b1;
        io_request_n     <= 1'b1;
      end
    end
  end

  // read data taken at the T4 entry edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      if (state_d == ST_T4 && state_q != ST_T4 && !req_q.write) rdata_q <= bus_data_in;
      rsp_q <= state_q == ST_T4 && last_clk;
    end
  end
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;

  a_t3_outputs_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q inside {ST_T3, ST_WAIT} && $past(state_q) inside {ST_T3, ST_WAIT}
    |-> $stable(write_n) && $stable(read_n) && $stable(bus_data_out) && $stable(chip_sel_n)
        && $stable(bus_addr) && $stable(bus_data_oe_n) && $stable(memory_request_n) && $stable(io_request_n))
    else $error("bus output moved during T3");
  a_order_t1_t2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T2 && $past(state_q) != ST_T2 |-> $past(state_q) == ST_T1)
    else $error("T2 not entered from T1");
  a_order_t4_from: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T4 && $past(state_q) != ST_T4 |-> $past(state_q) inside {ST_T3, ST_WAIT})
    else $error("T4 entered out of order");
  a_len_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy |-> len_q >= 4'h2 && cnt_q < len_q)
    else $error("state length out of range");
  a_latch_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T1 && $past(state_q) == ST_IDLE |-> addr_latch)
    else $error("latch strobe not high at T1 start");
  a_latch_low_t2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T2 |-> !addr_latch)
    else $error("latch strobe high after T1");
  a_strobe_t2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T2 |-> (read_n ^ write_n) && (memory_request_n ^ io_request_n))
    else $error("T2 strobes wrong");
  a_write_off_t4: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T4 |-> write_n && read_n && !chip_sel_n[req_q.cs])
    else $error("strobe still active in T4");
  a_wait_extends: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_WAIT && is_wait |=> state_q == ST_WAIT)
    else $error("wait state left while wait held");
  a_rsp_after_t4: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rsp_valid |-> $past(state_q) == ST_T4 && state_q == ST_IDLE)
    else $error("response not at T4 end");

  // latch falls once len_q/2 clocks of T1, rounded down, have gone by, whatever the state length
  a_latch_mid_t1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T1 |-> addr_latch == !half_clk)
    else $error("latch strobe not low midway through T1");
  a_sep_write_t1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T1 && !muxed_q && req_q.write |-> !bus_data_oe_n && bus_data_out == req_q.wdata)
    else $error("write data not driven in T1");
  a_select_t1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T1 |-> bus_addr == req_q.addr && !chip_sel_n[req_q.cs] && $onehot0(~chip_sel_n))
    else $error("address or select wrong in T1");
  a_write_strobe_t2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T2 && req_q.write |-> !write_n && read_n)
    else $error("write strobe not low in T2");
  a_request_held: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q inside {ST_T2, ST_T3, ST_WAIT, ST_T4} |-> memory_request_n == req_q.io && io_request_n == !req_q.io)
    else $error("memory or io request wrong");
  a_t3_entry_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T3 && $past(state_q) == ST_T2 |-> $stable(read_n) && $stable(write_n) && $stable(bus_data_out))
    else $error("bus output moved entering T3");
  a_wait_seen_t3: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T3 && last_clk && wait_hit_q |=> state_q == ST_WAIT)
    else $error("wait state not inserted");
  a_read_capture: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T4 && $past(state_q) != ST_T4 && !req_q.write |-> rsp_rdata == $past(bus_data_in))
    else $error("read data not taken at T4 start");
  a_t4_buses_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T4 && $past(state_q) == ST_T4 |-> $stable(bus_addr) && $stable(bus_data_out) && $stable(bus_data_oe_n))
    else $error("buses moved inside T4");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_IDLE |-> &chip_sel_n && read_n && write_n && memory_request_n && io_request_n
      && bus_data_oe_n)
    else $error("bus active while idle");
  a_muxed_addr_t1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T1 && muxed_q |-> !bus_data_oe_n && bus_data_out == bus_addr[`IBS_DATA_W-1:0])
    else $error("low address byte not on data bus");
  a_muxed_read_t2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T2 && muxed_q && !req_q.write |-> bus_data_oe_n && !read_n)
    else $error("muxed read still drives data bus in T2");
  a_muxed_latch_t1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T1 && muxed_q && $past(state_q) == ST_IDLE |-> addr_latch && !bus_data_oe_n)
    else $error("muxed write latch pulse missing");
  a_write_data_t2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T2 && req_q.write |-> !bus_data_oe_n && bus_data_out == req_q.wdata)
    else $error("write data not on data bus in T2");
  a_muxed_write_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_T4 && muxed_q && req_q.write |-> write_n && !bus_data_oe_n && bus_data_out == req_q.wdata)
    else $error("muxed write not ended cleanly in T4");
  a_muxed_full_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy && muxed_q |-> bus_addr == req_q.addr)
    else $error("full address missing in muxed cycle");
  a_native_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past(sys_rst) |-> cfg_rdata[0].mode == IBS_MODE_NATIVE && !req_ready)
    else $error("select not native after reset");
  a_refuse_native: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_IDLE && !sel_four |=> state_q == ST_IDLE)
    else $error("cycle started on a refused select");
  // the sequencer must only ever see the second stage
  a_wait_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> wait_s2_q == $past(wait_s1_q))
    else $error("wait synchroniser stage skipped");
endmodule

// ==== src/ibs_map.svh ====
// ibs_map.svh: constants for the four-state bus cycle sequencer
// included from both the package and the sequencer, guarded; definitions only
`ifndef IBS_MAP_SVH
`define IBS_MAP_SVH
`define IBS_STATE_LEN_MIN   4'h2
`define IBS_STATE_LEN_MAX   4'hF
`define IBS_STATE_LEN_RST   4'h2
`define IBS_ADDR_W          24
`define IBS_DATA_W          8
`define IBS_CS_N            4
`endif

// ==== src/ibs_pkg.sv ====
// ibs_pkg.sv: types for the four-state bus cycle sequencer
// assumes ibs_map.svh is on the include path
`include "ibs_map.svh"
package ibs_pkg;
  typedef enum logic [1:0] {
    IBS_MODE_NATIVE,
    IBS_MODE_SLOW3,
    IBS_MODE_FOUR,
    IBS_MODE_EIGHT
  } ibs_mode_t;

  typedef struct packed {
    logic [`IBS_ADDR_W-1:0] addr;
    logic [`IBS_DATA_W-1:0] wdata;
    logic                   write;
    logic                   io;
    logic [1:0]             cs;
  } ibs_req_t;

  typedef struct packed {
    ibs_mode_t  mode;
    logic       muxed;
    logic [3:0] state_len;
  } ibs_cs_cfg_t;
endpackage

// ==== tb/ibs_peer.sv ====
// ibs_peer.sv: byte-wide external memory on the far side of the sequencer
// assumes the bench sets stall_len before a cycle begins
`timescale 1ns/1ps
module ibs_peer (
  input  wire logic        ref_clk,
  input  wire logic [23:0] bus_addr,
  input  wire logic [7:0]  bus_data_out,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic [3:0]  chip_sel_n,
  input  wire logic [7:0]  stall_len,
  output logic [7:0]       bus_data_in,
  output logic             wait_n
);
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  logic [7:0] cnt_q = 8'h00;
  wire        sel = ~&chip_sel_n;
  // stall counted from select so the low level lands well before T3
  assign wait_n = !(sel && cnt_q < stall_len);
  // released bus shows the inverse of the last byte, not a stale copy
  assign bus_data_in = read_n ? ~last_q : mem[bus_addr[7:0]];
  always @(posedge ref_clk) begin
    cnt_q <= sel ? cnt_q + 8'h01 : 8'h00;
    if (!read_n)
      last_q <= mem[bus_addr[7:0]];
    if (sel && !write_n)
      mem[bus_addr[7:0]] <= bus_data_out;
  end
endmodule

// ==== tb/ibs_sequencer_tb.sv ====
// ibs_sequencer_tb.sv: self-checking bench for the four-state bus sequencer
// assumes ibs_peer answers on the external bus
`timescale 1ns/1ps
module ibs_sequencer_tb;
  import ibs_pkg::*;
  logic        ref_clk, sys_rst, req_valid, req_ready, rsp_valid, busy, bus_data_oe_n;
  logic        addr_latch, read_n, write_n, memory_request_n, io_request_n, wait_n;
  logic [3:0]  cfg_we, chip_sel_n;
  logic [7:0]  rsp_rdata, bus_data_out, bus_data_in, stall_len;
  logic [23:0] bus_addr;
  ibs_req_t    req;
  ibs_cs_cfg_t cfg_wdata;
  ibs_cs_cfg_t cfg_rdata [4];
  logic [7:0]  exp_mem [256];
  logic [31:0] seed = 32'h610e_1e73;
  int          bad_count = 0;
  int          checks_done = 0;
  int          lens [2];

  ibs_sequencer i_ibs_sequencer (.ref_clk, .sys_rst, .req, .req_valid, .req_ready, .rsp_valid,
    .rsp_rdata, .cfg_we, .cfg_wdata, .cfg_rdata, .busy, .bus_addr, .bus_data_in, .bus_data_out,
    .bus_data_oe_n, .chip_sel_n, .addr_latch, .read_n, .write_n, .memory_request_n,
    .io_request_n, .wait_n);
  ibs_peer i_ibs_peer (.ref_clk, .bus_addr, .bus_data_out, .read_n, .write_n, .chip_sel_n,
    .stall_len, .bus_data_in, .wait_n);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic xfer(input int cs, input bit wr, input bit io, input logic [23:0] a, input int stl);
    int         n;
    int         l;
    logic [7:0] wd;
    l = lens[cs];
    wd = 8'(rnd());
    req = '{addr: a, wdata: wd, write: wr, io: io, cs: 2'(cs)};
    stall_len = 8'(stl);
    req_valid = 1'b1;
    // ready is looked at on the rising edge that would take the request
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (req_ready === 1'b1)
        break;
    end
    if (n == 50) begin
      $display("ERROR %0t: request never taken", $time);
      bad_count++;
      test_done();
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    if (wr)
      exp_mem[a[7:0]] = wd;
    for (n = 0; n < 400; n++) begin
      if (n == 0) begin
        chk({bus_addr, chip_sel_n[cs], addr_latch}, {a, 2'b01});
        if (cs == 1 || wr)
          chk({bus_data_oe_n, bus_data_out}, {1'b0, cs == 1 ? a[7:0] : wd});
      end
      if (n == l - 1)
        chk(addr_latch, 0);
      if (n == l + 1)
        chk({read_n, write_n, memory_request_n, io_request_n}, {wr, !wr, io, !io});
      if (n == l + 1 && cs == 1)
        chk(bus_data_oe_n, !wr);
      if (n == l + 1 && wr)
        chk(bus_data_out, wd);
      if (n == 3 * l - 1)
        chk({read_n, write_n, memory_request_n, io_request_n}, {wr, !wr, io, !io});
      if (n == 3 * l + 1 && stl == 0)
        chk({read_n, write_n, bus_addr}, {2'b11, a});
      if (rsp_valid === 1'b1)
        break;
      @(negedge ref_clk);
    end
    if (n == 400) begin
      $display("ERROR %0t: no response", $time);
      bad_count++;
      test_done();
    end
    chk(chip_sel_n, 4'hF);
    if (stl == 0)
      chk(n, 4 * l);
    else
      chk(n > 4 * l && n % l == 0, 1);
    if (!wr)
      chk(rsp_rdata, exp_mem[a[7:0]]);
    $display("%s cs %0d len %0d done at %0t", wr ? "write" : "read", cs, l, $time);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    int          r;
    int          cs;
    int          io;
    logic [23:0] a;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    cfg_we = 4'h0;
    cfg_wdata = '0;
    stall_len = 8'h00;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk(cfg_rdata[2], {IBS_MODE_NATIVE, 1'b0, 4'h2});
    chk({read_n, write_n, chip_sel_n, bus_data_oe_n}, 7'h7F);
    // native select must never start a four-state cycle
    req.cs = 2'd2;
    req_valid = 1'b1;
    repeat (8) begin
      @(negedge ref_clk);
      chk({req_ready, chip_sel_n}, 5'h0F);
    end
    req_valid = 1'b0;
    $display("native refusal done at %0t", $time);
    for (r = 0; r < 2; r++) begin
      lens[0] = r ? 2 + rnd() % 14 : 2;
      lens[1] = r ? 2 + rnd() % 14 : 15;
      for (cs = 0; cs < 2; cs++) begin
        cfg_wdata = '{mode: IBS_MODE_FOUR, muxed: cs[0], state_len: 4'(lens[cs])};
        cfg_we = 4'(1 << cs);
        @(negedge ref_clk);
        cfg_we = 4'h0;
        @(negedge ref_clk);
        chk(cfg_rdata[cs], cfg_wdata);
        for (io = 0; io < 2; io++) begin
          a = 24'(rnd());
          xfer(cs, 1'b1, io[0], a, 0);
          xfer(cs, 1'b0, io[0], a, r ? 3 * lens[cs] : 0);
        end
      end
    end
    test_done();
  end
endmodule
